// ===== hdl/hti_target.sv
// What this block does
// - write bits sampled on serial clock rising edge
// - read bits driven after falling edge, held
// - fully static, no minimum clock rate
// - wait 100 ms after power before answering
// - answer only address 0x38, then direction bit
// - acknowledge after eighth falling edge, one bit
`timescale 1ns/1ns
module hti_target
	import hti_pkg::*;
#(
	parameter int unsigned PWR_WAIT = PWR_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic scl_clk,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic ready,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready
);
	logic [PWR_CNT_W-1:0] pwr_cnt_q, pwr_cnt_d; // settling counter, core domain
	logic ready_q, ready_d; // settling done
	logic rx_s1_q, rx_s2_q, rx_s3_q; // received-byte toggle sync
	logic tk_s1_q, tk_s2_q, tk_s3_q; // read-byte taken toggle sync
	logic [7:0] tx_hold_q, tx_hold_d; // byte offered for reads
	logic tx_full_q, tx_full_d; // offered byte valid
	logic rx_push, tx_taken; // one pulse per byte received or sent
	logic buf_room; // buffer accepts a word
	hti_state_e st_q, st_d; // bus sequencer state, link domain
	logic [2:0] cnt_q, cnt_d; // bit within byte
	logic [7:0] sh_q, sh_d; // incoming shift register
	logic [7:0] out_q, out_d; // outgoing shift register
	logic oe_q, oe_d; // pulling data low
	logic rw_q, rw_d; // direction of this transfer
	logic [7:0] rx_byte_q, rx_byte_d; // last byte written by host
	logic rx_tgl_q, rx_tgl_d; // flips per accepted byte
	logic take_q, take_d; // flips per offered byte loaded for a read
	logic seen_q, seen_d; // start toggle already handled
	logic smp_q; // data bit caught on rising clock
	logic start_tgl_q; // flips on each start condition
	logic rdy_s1_q, rdy_l2_q, room_s1_q, room_l2_q, txf_s1_q, txf_l2_q; // synced core levels
	logic start_pend; // start seen since last falling edge
	logic [7:0] byte_in, next_rd; // byte with the newest bit, byte to load for a read
	// open-drain data pin: only ever drive low
	assign sda_o = 1'b0;
	assign sda_oe = oe_q;
	assign ready = ready_q;
	assign tx_ready = !tx_full_q;
	// settling counter after reset release
	always_comb begin
		pwr_cnt_d = pwr_cnt_q;
		ready_d = ready_q;
		if (!ready_q) begin
			if (pwr_cnt_q == PWR_CNT_W'(PWR_WAIT - 1)) begin
				ready_d = 1'b1;
			end else begin
				pwr_cnt_d = pwr_cnt_q + 1'b1;
			end
		end
	end
	// settling registers
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pwr_cnt_q <= '0;
			ready_q <= 1'b0;
		end else begin
			pwr_cnt_q <= pwr_cnt_d;
			ready_q <= ready_d;
		end
	end
	// toggle synchronisers from the link
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_s1_q <= 1'b0;
			rx_s2_q <= 1'b0;
			rx_s3_q <= 1'b0;
			tk_s1_q <= 1'b0;
			tk_s2_q <= 1'b0;
			tk_s3_q <= 1'b0;
		end else begin
			rx_s1_q <= rx_tgl_q;
			rx_s2_q <= rx_s1_q;
			rx_s3_q <= rx_s2_q;
			tk_s1_q <= take_q;
			tk_s2_q <= tk_s1_q;
			tk_s3_q <= tk_s2_q;
		end
	end
	// edges of the synced toggles
	assign rx_push = rx_s2_q ^ rx_s3_q;
	assign tx_taken = tk_s2_q ^ tk_s3_q;
	// read-byte holding register
	always_comb begin
		tx_hold_d = tx_hold_q;
		tx_full_d = tx_full_q;
		if (tx_taken) begin
			tx_full_d = 1'b0;
		end else if (tx_valid && !tx_full_q) begin
			tx_hold_d = tx_data;
			tx_full_d = 1'b1;
		end
	end
	// holding registers
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_hold_q <= '0;
			tx_full_q <= 1'b0;
		end else begin
			tx_hold_q <= tx_hold_d;
			tx_full_q <= tx_full_d;
		end
	end
	// received bytes wait here until the user takes them
	hti_buf2 #(
		.WIDTH(BYTE_W),
		.DEPTH(RX_DEPTH)
	) u_rx_buf (
		.clk(core_clk),
		.rst_b(rst_b),
		.in_valid(rx_push),
		.in_ready(buf_room),
		.in_data(rx_byte_q),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_data)
	);
	// start condition: data falls while clock is high
	always_ff @(negedge sda_i or negedge rst_b) begin
		if (!rst_b) begin
			start_tgl_q <= 1'b0;
		end else if (scl_clk) begin
			start_tgl_q <= !start_tgl_q;
		end
	end
	// data captured on the rising clock edge
	always_ff @(posedge scl_clk or negedge rst_b) begin
		if (!rst_b) begin
			smp_q <= 1'b1;
		end else begin
			smp_q <= sda_i;
		end
	end
	// levels from the core, synced on the falling clock edge
	always_ff @(negedge scl_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdy_s1_q <= 1'b0;
			rdy_l2_q <= 1'b0;
			room_s1_q <= 1'b0;
			room_l2_q <= 1'b0;
			txf_s1_q <= 1'b0;
			txf_l2_q <= 1'b0;
		end else begin
			rdy_s1_q <= ready_q;
			rdy_l2_q <= rdy_s1_q;
			room_s1_q <= buf_room;
			room_l2_q <= room_s1_q;
			txf_s1_q <= tx_full_q;
			txf_l2_q <= txf_s1_q;
		end
	end
	assign start_pend = start_tgl_q != seen_q;
	assign byte_in = {sh_q[6:0], smp_q};
	// empty offer sends all ones
	assign next_rd = txf_l2_q ? tx_hold_q : IDLE_BYTE;
	// bus sequencer, stepped on each falling clock edge only
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		out_d = out_q;
		oe_d = 1'b0;
		rw_d = rw_q;
		rx_byte_d = rx_byte_q;
		rx_tgl_d = rx_tgl_q;
		take_d = take_q;
		seen_d = seen_q;
		if (start_pend) begin
			// first falling edge after a start opens the address byte
			seen_d = start_tgl_q;
			st_d = ST_ADDR;
			cnt_d = '0;
		end else begin
			case (st_q)
				ST_ADDR: begin
					sh_d = byte_in;
					cnt_d = cnt_q + 1'b1;
					if (cnt_q == LAST_BIT) begin
						// own address and settled: acknowledge
						if (rdy_l2_q && byte_in[7:1] == DEV_ADDR) begin
							st_d = ST_ADDR_ACK;
							oe_d = 1'b1;
							rw_d = byte_in[0];
						end else begin
							st_d = ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK: begin
					cnt_d = '0;
					if (rw_q == DIR_READ) begin
						// load first read byte, drive its top bit
						st_d = ST_RD;
						out_d = next_rd;
						oe_d = !next_rd[7];
						take_d = txf_l2_q ? !take_q : take_q;
					end else begin
						st_d = ST_WR;
					end
				end
				ST_WR: begin
					sh_d = byte_in;
					cnt_d = cnt_q + 1'b1;
					if (cnt_q == LAST_BIT) begin
						rx_byte_d = byte_in;
						if (room_l2_q) begin
							// byte stored: hand over and acknowledge
							rx_tgl_d = !rx_tgl_q;
							st_d = ST_WR_ACK;
							oe_d = 1'b1;
						end else begin
							// no room: leave line high, host sees refusal
							st_d = ST_IDLE;
						end
					end
				end
				ST_WR_ACK: begin
					cnt_d = '0;
					st_d = ST_WR;
				end
				ST_RD: begin
					cnt_d = cnt_q + 1'b1;
					if (cnt_q == LAST_BIT) begin
						// host answers in the ninth bit
						st_d = ST_RD_ACK;
					end else begin
						out_d = {out_q[6:0], 1'b1};
						oe_d = !out_q[6];
					end
				end
				ST_RD_ACK: begin
					cnt_d = '0;
					if (!smp_q) begin
						// host wants another byte
						st_d = ST_RD;
						out_d = next_rd;
						oe_d = !next_rd[7];
						take_d = txf_l2_q ? !take_q : take_q;
					end else begin
						st_d = ST_IDLE;
					end
				end
				default: begin
					st_d = ST_IDLE;
				end
			endcase
		end
	end
	// sequencer registers; no timeout, state waits for the next edge
	always_ff @(negedge scl_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= ST_IDLE;
			cnt_q <= '0;
			sh_q <= '0;
			out_q <= IDLE_BYTE;
			oe_q <= 1'b0;
			rw_q <= 1'b0;
			rx_byte_q <= '0;
			rx_tgl_q <= 1'b0;
			take_q <= 1'b0;
			seen_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			out_q <= out_d;
			oe_q <= oe_d;
			rw_q <= rw_d;
			rx_byte_q <= rx_byte_d;
			rx_tgl_q <= rx_tgl_d;
			take_q <= take_d;
			seen_q <= seen_d;
		end
	end
	// settling ends exactly when the counter runs out
	chk_ready_wait: assert property (@(posedge core_clk) disable iff (!rst_b)
		$rose(ready_q) |-> $past(pwr_cnt_q) == PWR_CNT_W'(PWR_WAIT - 1))
		else $error("ready raised at wrong count");
	// outside ST_RD and ST_WR_ACK, never pull the line before settling reached the link
	chk_quiet_unready: assert property (@(negedge scl_clk) disable iff (!rst_b)
		(!rdy_l2_q && st_q != ST_RD && st_q != ST_WR_ACK) |=> !oe_q)
		else $error("line driven before settling");
	// rising-edge capture follows the pin
	chk_sample_rise: assert property (@(posedge scl_clk) disable iff (!rst_b)
		1'b1 |=> smp_q == $past(sda_i))
		else $error("data not caught on rising clock");
	sequence s_addr_hit;
		st_q == ST_ADDR && cnt_q == LAST_BIT && !start_pend && rdy_l2_q
			&& byte_in[7:1] == DEV_ADDR;
	endsequence
	sequence s_ack_bit;
		oe_q && st_q == ST_ADDR_ACK ##1 st_q != ST_ADDR_ACK;
	endsequence
	// own address gives a one-bit acknowledge, then moves on
	chk_addr_ack: assert property (@(negedge scl_clk) disable iff (!rst_b)
		s_addr_hit |=> s_ack_bit)
		else $error("address acknowledge wrong");
	// foreign address leaves the line released
	chk_addr_miss: assert property (@(negedge scl_clk) disable iff (!rst_b)
		(st_q == ST_ADDR && cnt_q == LAST_BIT && !start_pend
			&& byte_in[7:1] != DEV_ADDR) |=> !oe_q && st_q == ST_IDLE)
		else $error("foreign address answered");
	// read bits follow the outgoing shift register
	chk_read_bit: assert property (@(negedge scl_clk) disable iff (!rst_b)
		(st_q == ST_RD && cnt_q != LAST_BIT && !start_pend) |=> oe_q == !$past(out_q[6]))
		else $error("read bit wrong");
	// released in every state that neither acknowledges nor sends
	chk_release_idle: assert property (@(negedge scl_clk) disable iff (!rst_b)
		(st_q == ST_IDLE || st_q == ST_ADDR || st_q == ST_WR || st_q == ST_RD_ACK) |-> !oe_q)
		else $error("line held while idle");
	// a write byte is not abandoned without a start
	chk_static_hold: assert property (@(negedge scl_clk) disable iff (!rst_b)
		(st_q == ST_WR && cnt_q != LAST_BIT && !start_pend) |=> st_q == ST_WR)
		else $error("write byte dropped");
endmodule

// ===== hdl/hti_pkg.sv
// shared constants for the sensor serial target interface
package hti_pkg;
	// core clock rate in hertz
	localparam int unsigned CORE_HZ = 50_000_000;
	// least settling time after power-up, in milliseconds
	localparam int unsigned PWR_UP_MS = 100;
	// settling time as core cycles, clock rate truncated to whole kilohertz
	localparam int unsigned PWR_CYCLES = (PWR_UP_MS * (CORE_HZ / 1000));
	// width of the settling counter
	localparam int unsigned PWR_CNT_W = 23;
	// fixed seven-bit bus address of the sensor
	localparam logic [6:0] DEV_ADDR = 7'h38;
	// direction bit value that asks for a read
	localparam logic DIR_READ = 1'b1;
	// bits in one byte on the wire
	localparam int unsigned BYTE_W = 8;
	// index of the last bit of a byte
	localparam logic [2:0] LAST_BIT = 3'h7;
	// value sent on a read when no byte is offered
	localparam logic [7:0] IDLE_BYTE = 8'hff;
	// depth of the receive buffer
	localparam int unsigned RX_DEPTH = 2;
	// states of the bus-side sequencer
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WR,
		ST_WR_ACK,
		ST_RD,
		ST_RD_ACK
	} hti_state_e;
endpackage

// ===== hdl/hti_buf2.sv
`timescale 1ns/1ns
// small first-in first-out buffer with valid and ready on both sides
module hti_buf2 #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 2
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH]; // storage words
	logic [PW-1:0] wr_ptr_q, wr_ptr_d; // next slot to fill
	logic [PW-1:0] rd_ptr_q, rd_ptr_d; // next slot to drain
	logic [CW-1:0] cnt_q, cnt_d; // words held
	logic push, pop;

	// honest full and empty from the word count
	assign in_ready = (cnt_q != CNT_FULL);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_ptr_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// pointer and count update
	always_comb begin
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		cnt_d = cnt_q;
		if (push) begin
			wr_ptr_d = (wr_ptr_q == PTR_LAST) ? '0 : wr_ptr_q + 1'b1;
		end
		if (pop) begin
			rd_ptr_d = (rd_ptr_q == PTR_LAST) ? '0 : rd_ptr_q + 1'b1;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	// pointer registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			cnt_q <= cnt_d;
		end
	end

	// storage, written only on an accepted word
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end
endmodule

// ===== test/hti_host.sv
`timescale 1ns/1ns
// host controller model: open-drain master that makes the serial clock
module hti_host #(
	parameter int unsigned QTR = 60 // quarter of one bit period in ns
) (
	input wire logic sda_w, // resolved data wire
	output logic scl_low, // pulls clock low
	output logic sda_low // pulls data low
);
	// lines released, clock stands high while idle and during power-up
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	// start: data falls while clock high
	task automatic start_bit();
		#QTR scl_low = 1'b0;
		#QTR sda_low = 1'b1;
		#QTR scl_low = 1'b1;
	endtask
	// stop: data rises while clock high, clock then stands high
	task automatic stop_bit();
		#QTR sda_low = 1'b1;
		#QTR scl_low = 1'b0;
		#QTR sda_low = 1'b0;
	endtask
	// one bit: data set while low, sampled at rise, watched until fall
	task automatic bit_io(input logic b, output logic got, output logic steady);
		#QTR sda_low = !b;
		#QTR scl_low = 1'b0;
		got = sda_w;
		#(2*QTR-2) steady = (sda_w === got);
		#2 scl_low = 1'b1;
	endtask
	// eight data bits then the acknowledge bit, msb first
	task automatic xfer(input logic [7:0] d_out, input logic ack_out,
		output logic [7:0] d_in, output logic ack_in, output logic steady);
		logic s;
		steady = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d_out[i], d_in[i], s);
			steady &= s;
		end
		bit_io(ack_out, ack_in, s);
		steady &= s;
	endtask
endmodule

// ===== test/hti_target_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
	$display("wrong value at %0t: got %h exp %h", $time, (a), (e)); end end
module hti_target_tb_top;
	import hti_pkg::*;
	localparam int unsigned PW = 20; // shortened power-up wait
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic rx_ready = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic tx_valid = 1'b0;
	logic sda_o, sda_oe, ready, rx_valid, tx_ready;
	logic [7:0] rx_data;
	wire scl_clk, sda_w, scl_low, sda_low;
	int error_cnt = 0;
	int comparisons = 0;
	logic [7:0] din; // byte seen by the host
	logic ack, stdy; // acknowledge level, wire steady while clock high
	// core clock, 20 ns period
	always #10 core_clk = ~core_clk;
	// pull-ups on both wires
	assign scl_clk = !scl_low;
	assign sda_w = !(sda_low || (sda_oe && !sda_o));
	hti_target #(.PWR_WAIT(PW)) dut (.core_clk(core_clk), .rst_b(rst_b), .scl_clk(scl_clk),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .ready(ready), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready));
	hti_host #(.QTR(3)) host (.sda_w(sda_w), .scl_low(scl_low), .sda_low(sda_low)); // 12 ns bit
	// counts, verdict, end of run
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// host writes one byte and expects the given acknowledge level
	task automatic wr(input logic [7:0] d, input logic exp_ack);
		host.xfer(d, 1'b1, din, ack, stdy);
		`CHK(ack, exp_ack)
		`CHK(stdy, 1'b1)
	endtask
	// take one received byte from the buffer
	task automatic rx(input logic [7:0] e);
		@(posedge core_clk);
		`CHK(rx_valid, 1'b1)
		`CHK(rx_data, e)
		rx_ready <= 1'b1;
		@(posedge core_clk);
		rx_ready <= 1'b0;
	endtask
	// ready stays low for the wait, then rises
	task automatic t_power();
		int n;
		n = 0;
		`CHK(ready, 1'b0)
		while (ready !== 1'b1 && n < PW + 10) begin
			@(posedge core_clk);
			n++;
		end
		`CHK(n, PW)
		if (ready !== 1'b1) begin
			error_cnt++;
			finish_test();
		end
		$display("test power done");
	endtask
	// writes with a long pause, buffer fills and the next byte is refused
	task automatic t_write();
		#7 host.start_bit();
		wr(8'h70, 1'b0);
		wr(8'ha5, 1'b0);
		#3000;
		wr(8'h3c, 1'b0);
		wr(8'hc3, 1'b1);
		host.stop_bit();
		`CHK(sda_oe, 1'b0)
		rx(8'ha5);
		rx(8'h3c);
		@(posedge core_clk);
		`CHK(rx_valid, 1'b0)
		$display("test write done");
	endtask
	// other addresses get no acknowledge
	task automatic t_addr();
		logic [7:0] bad [2] = '{8'h72, 8'hf0};
		foreach (bad[i]) begin
			host.start_bit();
			wr(bad[i], 1'b1);
			host.stop_bit();
		end
		`CHK(sda_oe, 1'b0)
		$display("test address done");
	endtask
	// offered byte read back, then the idle byte when nothing is offered
	task automatic t_read();
		int n;
		n = 0;
		@(posedge core_clk);
		tx_data <= 8'h5a;
		tx_valid <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (tx_ready !== 1'b1 && n < 20);
		tx_valid <= 1'b0;
		if (n >= 20) begin
			error_cnt++;
			finish_test();
		end
		#5 host.start_bit();
		wr(8'h71, 1'b0);
		host.xfer(8'hff, 1'b0, din, ack, stdy);
		`CHK(din, 8'h5a)
		`CHK(stdy, 1'b1)
		host.xfer(8'hff, 1'b1, din, ack, stdy);
		`CHK(din, IDLE_BYTE)
		host.stop_bit();
		`CHK(sda_oe, 1'b0)
		$display("test read done");
	endtask
	// reset, then every scenario in turn
	initial begin
		repeat (12) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		t_power();
		t_write();
		t_addr();
		t_read();
		finish_test();
	end
endmodule
